// File: src/mpsc_power_sleep_control.v
// Power key, hard restart, sleep and wake control of the modem module
`include "mpsc_consts.vh"

module mpsc_power_sleep_control #(
	parameter TICK_CYCLES = `MPSC_TICK_CYCLES
) (
	clk,
	reset,
	supply_ok,
	power_key_n,
	power_key_pu,
	hard_restart_n,
	hard_restart_pu,
	sleep_permit,
	wake_source,
	sleep_request,
	power_on,
	system_reset,
	startup_report,
	usb_dp_attach,
	host_wake,
	awake_status,
	hs_uart_enable
);
	input wire clk;
	input wire reset;
	input wire supply_ok;
	input wire power_key_n;
	output reg power_key_pu;
	input wire hard_restart_n;
	output reg hard_restart_pu;
	input wire sleep_permit;
	input wire wake_source;
	input wire sleep_request;
	output reg power_on;
	output reg system_reset;
	output reg startup_report;
	output reg usb_dp_attach;
	output reg host_wake;
	output reg awake_status;
	output reg hs_uart_enable;

	// States, one-hot
	localparam ST_OFF = 6'h01;
	localparam ST_BOOT = 6'h02;
	localparam ST_RUN = 6'h04;
	localparam ST_SLEEP = 6'h08;
	localparam ST_DOWN = 6'h10;
	localparam ST_RESET = 6'h20;

	// ====================================================
	// Input synchronisers
	// ====================================================
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	// Idle pin levels after reset
	// Avoids a false wake edge and a false permit
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sync1_q <= `MPSC_SYNC_RST;
			sync2_q <= `MPSC_SYNC_RST;
		end
		else
		begin
			sync1_q <= {supply_ok, power_key_n, hard_restart_n, sleep_permit, wake_source};
			sync2_q <= sync1_q;
		end
	end
	wire supply_s = sync2_q[4];
	wire key_low = ~sync2_q[3];
	wire rst_low = ~sync2_q[2];
	wire permit_s = sync2_q[1];
	wire wake_s = sync2_q[0];

	// ====================================================
	// Free-running timebase
	// ====================================================
	reg [19:0] tick_cnt_q;
	reg tick_q;
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tick_cnt_q <= `MPSC_TICK_CNT_RST;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q == TICK_CYCLES - 1)
		begin
			tick_cnt_q <= `MPSC_TICK_CNT_RST;
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 20'h00001;
			tick_q <= 1'b0;
		end
	end

	// ====================================================
	// Hold timers for power key and restart input
	// ====================================================
	// Counters saturate so a stuck pin never wraps to a short hold
	reg [10:0] key_t_q;
	reg [10:0] rst_t_q;
	reg key_low_q;
	reg rst_low_q;
	wire key_rel = key_low_q & ~key_low;
	wire rst_rel = rst_low_q & ~rst_low;
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			key_t_q <= `MPSC_TIME_CNT_RST;
			rst_t_q <= `MPSC_TIME_CNT_RST;
			key_low_q <= 1'b0;
			rst_low_q <= 1'b0;
		end
		else
		begin
			key_low_q <= key_low;
			rst_low_q <= rst_low;
			if (!key_low)
				key_t_q <= `MPSC_TIME_CNT_RST;
			else if (tick_q && key_t_q != 11'h7ff)
				key_t_q <= key_t_q + 11'h001;
			if (!rst_low)
				rst_t_q <= `MPSC_TIME_CNT_RST;
			else if (tick_q && rst_t_q != 11'h7ff)
				rst_t_q <= rst_t_q + 11'h001;
		end
	end
	wire key_on_ok = key_t_q >= `MPSC_TON_MIN_T;
	wire key_off_ok = key_t_q >= `MPSC_TOFF_MIN_T;
	wire rst_too_long = rst_t_q >= `MPSC_RST_MAX_T;

	// ====================================================
	// Power sequencer
	// ====================================================
	reg [5:0] state_q;
	reg [5:0] state_d;
	reg [10:0] seq_t_q;
	reg seq_clr;
	always @*
	begin
		state_d = state_q;
		seq_clr = 1'b0;
		case (state_q)
			ST_OFF:
				if (supply_s && key_low && key_on_ok)
				begin
					state_d = ST_BOOT;
					seq_clr = 1'b1;
				end
			ST_BOOT:
				if (!supply_s)
					state_d = ST_OFF;
				else if (seq_t_q >= `MPSC_DP_ON_T - 1)
					state_d = ST_RUN;
			ST_RUN, ST_SLEEP:
				if (!supply_s)
					state_d = ST_OFF;
				else if (rst_low && rst_too_long)
				begin
					state_d = ST_DOWN;
					seq_clr = 1'b1;
				end
				else if (rst_rel)
				begin
					state_d = ST_RESET;
					seq_clr = 1'b1;
				end
				else if (key_rel && key_off_ok)
				begin
					state_d = ST_DOWN;
					seq_clr = 1'b1;
				end
				else if (state_q == ST_RUN && sleep_request && !permit_s && !wake_s)
					state_d = ST_SLEEP;
				else if (state_q == ST_SLEEP && (permit_s || wake_s || !sleep_request))
					state_d = ST_RUN;
			ST_RESET:
				begin
					state_d = ST_BOOT;
					seq_clr = 1'b1;
				end
			ST_DOWN:
				if (seq_t_q >= `MPSC_DP_OFF_T - 1)
					state_d = ST_OFF;
			default:
				state_d = ST_OFF;
		endcase
	end

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= ST_OFF;
			seq_t_q <= `MPSC_TIME_CNT_RST;
		end
		else
		begin
			state_q <= state_d;
			if (seq_clr)
				seq_t_q <= `MPSC_TIME_CNT_RST;
			else if (tick_q && seq_t_q != 11'h7ff)
				seq_t_q <= seq_t_q + 11'h001;
		end
	end

	// ====================================================
	// Wake pulse to the host
	// ====================================================
	// A running pulse masks new wake edges
	reg [10:0] wake_t_q;
	reg wake_prev_q;
	wire wake_rise = wake_s & ~wake_prev_q;
	wire live = state_q == ST_RUN || state_q == ST_SLEEP;
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wake_t_q <= `MPSC_TIME_CNT_RST;
			wake_prev_q <= 1'b0;
			host_wake <= 1'b0;
		end
		else
		begin
			wake_prev_q <= wake_s;
			if (host_wake)
			begin
				if (tick_q)
				begin
					if (wake_t_q >= `MPSC_WAKE_T - 1)
					begin
						host_wake <= 1'b0;
						wake_t_q <= `MPSC_TIME_CNT_RST;
					end
					else
						wake_t_q <= wake_t_q + 11'h001;
				end
			end
			else if (wake_rise && live)
			begin
				host_wake <= 1'b1;
				wake_t_q <= `MPSC_TIME_CNT_RST;
			end
		end
	end

	// ====================================================
	// Registered outputs
	// ====================================================
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			power_key_pu <= 1'b1;
			hard_restart_pu <= 1'b1;
			power_on <= 1'b0;
			system_reset <= 1'b1;
			startup_report <= 1'b0;
			usb_dp_attach <= 1'b0;
			awake_status <= 1'b0;
			hs_uart_enable <= 1'b0;
		end
		else
		begin
			power_key_pu <= 1'b1;
			hard_restart_pu <= 1'b1;
			power_on <= state_d != ST_OFF;
			system_reset <= state_d == ST_OFF || state_d == ST_RESET;
			startup_report <= state_q == ST_BOOT && state_d == ST_RUN;
			usb_dp_attach <= state_d == ST_RUN || state_d == ST_SLEEP;
			awake_status <= state_d == ST_RUN || state_d == ST_BOOT;
			hs_uart_enable <= permit_s && state_d == ST_RUN;
		end
	end

endmodule // mpsc_power_sleep_control

// File: src/mpsc_consts.vh
// Timing and encoding constants for the power and sleep control block
`ifndef MPSC_CONSTS_VH
`define MPSC_CONSTS_VH

// Clock period in ns
`define MPSC_CLK_NS 10
// Timebase tick period in ms
`define MPSC_TICK_MS 10
// Clock cycles per timebase tick (10 ms at 10 ns)
`define MPSC_TICK_CYCLES (`MPSC_TICK_MS * 1000000 / `MPSC_CLK_NS)
// Times in ms, as printed
`define MPSC_TON_MIN_MS 500
`define MPSC_TON_MAX_MS 1000
`define MPSC_TOFF_MIN_MS 3500
`define MPSC_TOFF_MAX_MS 5000
`define MPSC_DP_ON_MS 12000
`define MPSC_DP_OFF_EXTRA_MS 500
`define MPSC_RST_MAX_MS 1000
`define MPSC_WAKE_MS 1000
// Tick counts derived from times
`define MPSC_TON_MIN_T (`MPSC_TON_MIN_MS / `MPSC_TICK_MS)
`define MPSC_TOFF_MIN_T (`MPSC_TOFF_MIN_MS / `MPSC_TICK_MS)
`define MPSC_DP_ON_T (`MPSC_DP_ON_MS / `MPSC_TICK_MS)
`define MPSC_DP_OFF_T (`MPSC_DP_OFF_EXTRA_MS / `MPSC_TICK_MS)
`define MPSC_RST_MAX_T (`MPSC_RST_MAX_MS / `MPSC_TICK_MS)
`define MPSC_WAKE_T (`MPSC_WAKE_MS / `MPSC_TICK_MS)
// Reset values
`define MPSC_TICK_CNT_RST 20'h00000
`define MPSC_TIME_CNT_RST 11'h000
// Synchroniser reset at idle pin levels: supply, key, restart, permit, wake
`define MPSC_SYNC_RST 5'h0c

`endif

// File: verification/mpsc_psc_asserts.sv
// Concurrent checks on the power and sleep control ports
module mpsc_psc_asserts #(
	parameter TICK_CYCLES = 1000000
) (
	input logic clk,
	input logic reset,
	input logic supply_ok,
	input logic power_key_n,
	input logic power_key_pu,
	input logic hard_restart_pu,
	input logic sleep_permit,
	input logic power_on,
	input logic system_reset,
	input logic startup_report,
	input logic usb_dp_attach,
	input logic host_wake,
	input logic hs_uart_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T = TICK_CYCLES;
	int boot_q;
	int off_q;
	int wake_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// ==========
	// Cycles since boot, since D+ drop, of wake high
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			boot_q <= 0;
			off_q <= 0;
			wake_q <= 0;
		end
		else
		begin
			boot_q <= system_reset ? 0 : boot_q + 1;
			off_q <= usb_dp_attach ? 0 : off_q + 1;
			wake_q <= host_wake ? wake_q + 1 : 0;
		end
	end
	sequence s_boot_start;
		$rose(power_on);
	endsequence
	sequence s_restart_pulse;
		system_reset && power_on ##1 !system_reset;
	endsequence
	// ==========
	// Assertions
	AST_PULLUPS: assert property (power_key_pu && hard_restart_pu)
		else $error("pull-up enable low");
	AST_BOOT_KEY: assert property (s_boot_start |-> !power_key_n && supply_ok)
		else $error("boot without key press");
	AST_DP_ON: assert property ($rose(usb_dp_attach) |-> boot_q inside {[1198*T:1201*T+4]})
		else $error("D+ rise time off");
	AST_REPORT: assert property (startup_report |-> boot_q inside {[1198*T:1201*T+4]})
		else $error("startup report time off");
	AST_RESTART: assert property (system_reset && power_on |-> s_restart_pulse)
		else $error("restart pulse too long");
	AST_OFF: assert property ($fell(power_on) |-> off_q inside {[48*T:51*T+4]})
		else $error("power off delay off");
	AST_WAKE_LEN: assert property ($fell(host_wake) |-> wake_q inside {[99*T:101*T+4]})
		else $error("wake pulse length off");
	AST_UART: assert property ($fell(sleep_permit) |-> ##[1:5] !hs_uart_enable)
		else $error("uart still enabled");
endmodule // mpsc_psc_asserts

// File: verification/mpsc_host_model.sv
// Host model driving the power key and restart pins
module mpsc_host_model (
	input logic clk,
	output logic power_key_n,
	output logic hard_restart_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		power_key_n = 1'b1;
		hard_restart_n = 1'b1;
	end
	// Timed low pulse, then release to the pulled-up level
	task automatic pulse(input bit which, input int n);
		@(negedge clk);
		if (which)
			hard_restart_n = 1'b0;
		else
			power_key_n = 1'b0;
		repeat (n) @(negedge clk);
		power_key_n = 1'b1;
		hard_restart_n = 1'b1;
	endtask
endmodule // mpsc_host_model

// File: verification/tb_mpsc_power_sleep_control.sv
// Self-checking bench for the power and sleep control block
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0b got %0b", nm, e, g); end end
module tb_mpsc_power_sleep_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T = 10;
	logic clk, reset, supply_ok, sleep_permit, wake_source, sleep_request;
	wire power_key_n, hard_restart_n, power_key_pu, hard_restart_pu, power_on, system_reset;
	wire startup_report, usb_dp_attach, host_wake, awake_status, hs_uart_enable;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	mpsc_power_sleep_control #(.TICK_CYCLES(T)) u_mpsc_power_sleep_control (.clk(clk),
		.reset(reset), .supply_ok(supply_ok), .power_key_n(power_key_n),
		.power_key_pu(power_key_pu), .hard_restart_n(hard_restart_n),
		.hard_restart_pu(hard_restart_pu), .sleep_permit(sleep_permit),
		.wake_source(wake_source), .sleep_request(sleep_request), .power_on(power_on),
		.system_reset(system_reset), .startup_report(startup_report),
		.usb_dp_attach(usb_dp_attach), .host_wake(host_wake),
		.awake_status(awake_status), .hs_uart_enable(hs_uart_enable));
	mpsc_host_model u_mpsc_host_model (.clk(clk), .power_key_n(power_key_n),
		.hard_restart_n(hard_restart_n));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_power_on();
		u_mpsc_host_model.pulse(0, 70 * T);
		`CHK("power_on", 1'b1, power_on)
		`CHK("awake", 1'b1, awake_status)
		for (int i = 0; i < 13000 && usb_dp_attach !== 1'b1; i++) @(negedge clk);
		`CHK("dp_on", 1'b1, usb_dp_attach)
	endtask
	task automatic t_wake();
		wake_source = 1'b1;
		repeat (10) @(negedge clk);
		wake_source = 1'b0;
		repeat (300) @(negedge clk);
		`CHK("wake_hi", 1'b1, host_wake)
		wake_source = 1'b1;
		repeat (10) @(negedge clk);
		wake_source = 1'b0;
		repeat (750) @(negedge clk);
		`CHK("wake_lo", 1'b0, host_wake)
	endtask
	task automatic t_sleep();
		sleep_permit = 1'b1;
		sleep_request = 1'b1;
		repeat (10) @(negedge clk);
		`CHK("uart_on", 1'b1, hs_uart_enable)
		`CHK("no_sleep", 1'b1, awake_status)
		sleep_permit = 1'b0;
		repeat (10) @(negedge clk);
		`CHK("uart_off", 1'b0, hs_uart_enable)
		`CHK("asleep", 1'b0, awake_status)
		sleep_request = 1'b0;
		repeat (10) @(negedge clk);
		`CHK("rewake", 1'b1, awake_status)
	endtask
	task automatic t_restart();
		u_mpsc_host_model.pulse(1, 20 * T);
		for (int i = 0; i < 13000 && startup_report !== 1'b1; i++) @(negedge clk);
		`CHK("report", 1'b1, startup_report)
	endtask
	task automatic t_power_off();
		u_mpsc_host_model.pulse(0, 400 * T);
		repeat (10) @(negedge clk);
		`CHK("dp_off", 1'b0, usb_dp_attach)
		`CHK("still_on", 1'b1, power_on)
		repeat (50 * T + 10) @(negedge clk);
		`CHK("off", 1'b0, power_on)
	endtask
	task automatic t_long_restart();
		t_power_on();
		u_mpsc_host_model.pulse(1, 110 * T);
		repeat (50 * T + 10) @(negedge clk);
		`CHK("rst_off", 1'b0, power_on)
	endtask
	initial
	begin
		reset = 1'b1;
		supply_ok = 1'b1;
		sleep_permit = 1'b0;
		wake_source = 1'b0;
		sleep_request = 1'b0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		t_power_on();
		t_wake();
		t_sleep();
		t_restart();
		t_power_off();
		t_long_restart();
		print_verdict();
	end
endmodule // tb_mpsc_power_sleep_control
bind mpsc_power_sleep_control mpsc_psc_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_mpsc_psc_asserts (
	.clk(clk), .reset(reset), .supply_ok(supply_ok), .power_key_n(power_key_n),
	.power_key_pu(power_key_pu), .hard_restart_pu(hard_restart_pu),
	.sleep_permit(sleep_permit), .power_on(power_on), .system_reset(system_reset),
	.startup_report(startup_report), .usb_dp_attach(usb_dp_attach), .host_wake(host_wake),
	.hs_uart_enable(hs_uart_enable));
